//--- flash_frontend_defs.vh
// constants for the serial flash command front end
// included by the front end, its pin synchroniser and its sector protect store
`ifndef FLASH_FRONTEND_DEFS_VH
`define FLASH_FRONTEND_DEFS_VH

`define ADR_W        21
`define SECT_W       5
`define SECT_N       32
`define SECT_MSB     20
`define SECT_LSB     16

// supported opcodes
`define OPC_RD_DUM2  8'h1b
`define OPC_RD_DUM1  8'h0b
`define OPC_RD_DUM0  8'h03
`define OPC_RD_DUAL  8'h3b
`define OPC_ERASE4   8'h20
`define OPC_ERASE32  8'h52
`define OPC_ERASE64  8'hd8
`define OPC_CHIP     8'hc7
`define OPC_PROG     8'h02
`define OPC_PROG_DU  8'ha2
`define OPC_SUSPEND  8'hb0
`define OPC_RESUME   8'hd0
`define OPC_WREN     8'h06
`define OPC_WRDI     8'h04
`define OPC_PROT     8'h36
`define OPC_UNPROT   8'h39
`define OPC_RDPROT   8'h3c

// command kinds, also presented on op_kind_o
`define K_READ       4'h0
`define K_DREAD      4'h1
`define K_PROG       4'h2
`define K_DPROG      4'h3
`define K_ERASE4     4'h4
`define K_ERASE32    4'h5
`define K_ERASE64    4'h6
`define K_CHIP       4'h7
`define K_SUSPEND    4'h8
`define K_RESUME     4'h9
`define K_WREN       4'ha
`define K_WRDI       4'hb
`define K_PROT       4'hc
`define K_UNPROT     4'hd
`define K_RDPROT     4'he

// decode word: {known, gated, has_addr, dummy[1:0], kind[3:0]}
`define INFO_KNOWN   8
`define INFO_GATED   7
`define INFO_ADDR    6
`define INFO_DUM_MSB 5
`define INFO_DUM_LSB 4
`define INFO_K_MSB   3
`define INFO_RD      3'b101
`define INFO_WA      3'b111
`define INFO_WO      3'b110
`define INFO_OO      3'b100
`define DUM_0        2'h0
`define DUM_1        2'h1
`define DUM_2        2'h2

// bit counts within a phase (last index); PROG_FULL is the program byte counter full bit
`define LAST_BYTE    5'h07
`define LAST_DUAL    5'h03
`define LAST_ADDR    5'h17
`define PROG_FULL    8

// synchroniser: cs_n, sck, input pin, output pin; cs_n resets deselected
`define SYNC_W       4
`define SYNC_RST     4'h8
`define PIN_CS       3
`define PIN_SCK      2
`define PIN_SI       1
`define PIN_SO       0

`endif

//--- pin_sync.v
// two flip-flop synchroniser for the serial pins
// inputs are asynchronous to sys_clk_i; reset value is a constant
`timescale 1ns/1ps
`include "flash_frontend_defs.vh"
module pin_sync (
   input  wire                 sys_clk_i,
   input  wire                 rst_i,
   input  wire [`SYNC_W-1:0]   d_i,
   output reg  [`SYNC_W-1:0]   q_o
);
   reg [`SYNC_W-1:0] meta_r;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= `SYNC_RST;
         q_o    <= `SYNC_RST;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule // pin_sync

//--- sector_protect.v
// per-sector protection flags, one per 64 kB sector
// set and clear are one-cycle pulses from the front end
`timescale 1ns/1ps
`include "flash_frontend_defs.vh"
module sector_protect (
   input  wire                 sys_clk_i,
   input  wire                 rst_i,
   input  wire                 set_i,
   input  wire                 clr_i,
   input  wire [`SECT_W-1:0]   idx_i,
   output wire [`SECT_N-1:0]   map_o
);
   genvar g;
   generate
      for (g = 0; g < `SECT_N; g = g + 1) begin : g_sect
         reg flag_r;
         always @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
               flag_r <= 1'b0;
            end else if (idx_i == g) begin
               if (set_i) begin
                  flag_r <= 1'b1;
               end else if (clr_i) begin
                  flag_r <= 1'b0;
               end
            end
         end
         assign map_o[g] = flag_r;
      end
   endgenerate
endmodule // sector_protect

//--- serial_flash_command_frontend.v
// serial flash command front end: frames, shifts and decodes host commands
// pins are sampled by sys_clk_i; sck must stay at least 4 sys_clk cycles per half period
// rd_data_i is expected valid in the same cycle as rd_strobe_o; it is sampled on the next edge
`timescale 1ns/1ps
`include "flash_frontend_defs.vh"
module serial_flash_command_frontend (
   input  wire                 sys_clk_i,
   input  wire                 rst_i,
   input  wire                 cs_n_i,
   input  wire                 sck_i,
   input  wire                 input_pin_bidir_i,
   output reg                  input_pin_bidir_o,
   output reg                  input_pin_bidir_oe_o,
   input  wire                 output_pin_bidir_i,
   output reg                  output_pin_bidir_o,
   output reg                  output_pin_bidir_oe_o,
   output reg                  rd_strobe_o,
   output reg  [`ADR_W-1:0]    rd_addr_o,
   input  wire [7:0]           rd_data_i,
   output reg                  prog_valid_o,
   output reg  [`ADR_W-1:0]    prog_addr_o,
   output reg  [7:0]           prog_data_o,
   output reg                  op_valid_o,
   output reg  [3:0]           op_kind_o,
   output reg  [`ADR_W-1:0]    op_addr_o,
   output wire                 write_enable_latch_o,
   output wire [`SECT_N-1:0]   sector_prot_o
);
   localparam S_IDLE   = 3'h0;
   localparam S_ADDR   = 3'h1;
   localparam S_DUMMY  = 3'h2;
   localparam S_RDATA  = 3'h3;
   localparam S_PDATA  = 3'h4;
   localparam S_DONE   = 3'h5;
   localparam S_IGNORE = 3'h6;

   wire [`SYNC_W-1:0] pins_s;
   reg  [2:0]         state_r;
   reg  [4:0]         bit_cnt_r;
   reg  [7:0]         op_r;
   reg  [3:0]         kind_r;
   reg                gated_r;
   reg  [1:0]         dum_r;
   reg  [`ADR_W-1:0]  addr_r;
   reg  [`ADR_W-1:0]  hdr_addr_r;
   reg  [7:0]         din_r;
   reg  [7:0]         dout_r;
   reg  [`PROG_FULL:0] byte_cnt_r;
   reg                wel_r;
   reg                load_r;
   reg                sck_q_r;
   reg                prot_set_r;
   reg                prot_clr_r;

   wire               cs_n_s   = pins_s[`PIN_CS];
   wire               sck_s    = pins_s[`PIN_SCK];
   wire               si_s     = pins_s[`PIN_SI];
   wire               so_s     = pins_s[`PIN_SO];
   wire               sck_rise = sck_s & ~sck_q_r;
   wire               sck_fall = ~sck_s & sck_q_r;
   wire               dual_rd  = (kind_r == `K_DREAD);
   wire               dual_wr  = (kind_r == `K_DPROG);
   wire [4:0]         last_rd  = dual_rd ? `LAST_DUAL : `LAST_BYTE;
   wire [4:0]         last_wr  = dual_wr ? `LAST_DUAL : `LAST_BYTE;
   wire [7:0]         op_nxt   = {op_r[6:0], si_s};
   wire [`ADR_W-1:0]  addr_nxt = {addr_r[`ADR_W-2:0], si_s};
   wire [7:0]         din_nxt  = dual_wr ? {din_r[5:0], so_s, si_s} : {din_r[6:0], si_s};
   wire [8:0]         info     = cmd_info(op_nxt);
   wire               prot_bit = sector_prot_o[rd_addr_o[`SECT_MSB:`SECT_LSB]];

   assign write_enable_latch_o = wel_r;

   // opcode decode: known, write-gated, address, dummy bytes, kind
   function [8:0] cmd_info;
      input [7:0] op;
      begin
         case (op)
            `OPC_RD_DUM2: cmd_info = {`INFO_RD, `DUM_2, `K_READ};
            `OPC_RD_DUM1: cmd_info = {`INFO_RD, `DUM_1, `K_READ};
            `OPC_RD_DUM0: cmd_info = {`INFO_RD, `DUM_0, `K_READ};
            `OPC_RD_DUAL: cmd_info = {`INFO_RD, `DUM_1, `K_DREAD};
            `OPC_ERASE4:  cmd_info = {`INFO_WA, `DUM_0, `K_ERASE4};
            `OPC_ERASE32: cmd_info = {`INFO_WA, `DUM_0, `K_ERASE32};
            `OPC_ERASE64: cmd_info = {`INFO_WA, `DUM_0, `K_ERASE64};
            `OPC_CHIP:    cmd_info = {`INFO_WO, `DUM_0, `K_CHIP};
            `OPC_PROG:    cmd_info = {`INFO_WA, `DUM_0, `K_PROG};
            `OPC_PROG_DU: cmd_info = {`INFO_WA, `DUM_0, `K_DPROG};
            `OPC_SUSPEND: cmd_info = {`INFO_OO, `DUM_0, `K_SUSPEND};
            `OPC_RESUME:  cmd_info = {`INFO_OO, `DUM_0, `K_RESUME};
            `OPC_WREN:    cmd_info = {`INFO_OO, `DUM_0, `K_WREN};
            `OPC_WRDI:    cmd_info = {`INFO_OO, `DUM_0, `K_WRDI};
            `OPC_PROT:    cmd_info = {`INFO_WA, `DUM_0, `K_PROT};
            `OPC_UNPROT:  cmd_info = {`INFO_WA, `DUM_0, `K_UNPROT};
            `OPC_RDPROT:  cmd_info = {`INFO_RD, `DUM_0, `K_RDPROT};
            default:      cmd_info = 9'h000;
         endcase
      end
   endfunction

   // protection reads are served from the flag map, not the array
   function is_prot_rd;
      input [3:0] k;
      begin
         is_prot_rd = (k == `K_RDPROT);
      end
   endfunction

   // fetch one byte at a and step the address with 21-bit wrap
   task start_fetch;
      input [`ADR_W-1:0] a;
      begin
         rd_strobe_o <= !is_prot_rd(kind_r);
         rd_addr_o   <= a;
         addr_r      <= a + 21'h000001;
         load_r      <= 1'b1;
      end
   endtask

   // header complete: enter the data phase of the command
   task enter_data;
      input [`ADR_W-1:0] a;
      begin
         hdr_addr_r <= a;
         bit_cnt_r  <= 5'h00;
         case (kind_r)
            `K_READ, `K_DREAD, `K_RDPROT: begin
               state_r <= S_RDATA;
               start_fetch(a);
            end
            `K_PROG, `K_DPROG: begin
               state_r <= S_PDATA;
               addr_r  <= a;
            end
            default: begin
               state_r <= S_DONE;
            end
         endcase
      end
   endtask

   pin_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .d_i       ({cs_n_i, sck_i, input_pin_bidir_i, output_pin_bidir_i}),
      .q_o       (pins_s)
   );

   sector_protect u_prot (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .set_i     (prot_set_r),
      .clr_i     (prot_clr_r),
      .idx_i     (hdr_addr_r[`SECT_MSB:`SECT_LSB]),
      .map_o     (sector_prot_o)
   );

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r               <= S_IDLE;
         bit_cnt_r             <= 5'h00;
         op_r                  <= 8'h00;
         kind_r                <= 4'h0;
         gated_r               <= 1'b0;
         dum_r                 <= 2'h0;
         addr_r                <= 21'h000000;
         hdr_addr_r            <= 21'h000000;
         din_r                 <= 8'h00;
         dout_r                <= 8'h00;
         byte_cnt_r            <= 9'h000;
         wel_r                 <= 1'b0;
         load_r                <= 1'b0;
         sck_q_r               <= 1'b0;
         prot_set_r            <= 1'b0;
         prot_clr_r            <= 1'b0;
         input_pin_bidir_o     <= 1'b0;
         input_pin_bidir_oe_o  <= 1'b0;
         output_pin_bidir_o    <= 1'b0;
         output_pin_bidir_oe_o <= 1'b0;
         rd_strobe_o           <= 1'b0;
         rd_addr_o             <= 21'h000000;
         prog_valid_o          <= 1'b0;
         prog_addr_o           <= 21'h000000;
         prog_data_o           <= 8'h00;
         op_valid_o            <= 1'b0;
         op_kind_o             <= 4'h0;
         op_addr_o             <= 21'h000000;
      end else begin
         // edges are tracked at all times so either idle level is fine
         sck_q_r      <= sck_s;
         rd_strobe_o  <= 1'b0;
         prog_valid_o <= 1'b0;
         op_valid_o   <= 1'b0;
         prot_set_r   <= 1'b0;
         prot_clr_r   <= 1'b0;
         if (load_r) begin
            load_r <= 1'b0;
            dout_r <= is_prot_rd(kind_r) ? {8{prot_bit}} : rd_data_i;
         end
         if (cs_n_s) begin
            // deselect: commit a complete command, drop anything partial
            if (state_r == S_DONE || (state_r == S_PDATA && byte_cnt_r != 9'h000)) begin
               case (kind_r)
                  `K_WREN: begin
                     wel_r <= 1'b1;
                  end
                  `K_WRDI: begin
                     wel_r <= 1'b0;
                  end
                  `K_PROT: begin
                     prot_set_r <= 1'b1;
                     wel_r      <= 1'b0;
                  end
                  `K_UNPROT: begin
                     prot_clr_r <= 1'b1;
                     wel_r      <= 1'b0;
                  end
                  default: begin
                     op_valid_o <= 1'b1;
                     op_kind_o  <= kind_r;
                     op_addr_o  <= hdr_addr_r;
                     if (gated_r) begin
                        wel_r <= 1'b0;
                     end
                  end
               endcase
            end
            state_r               <= S_IDLE;
            bit_cnt_r             <= 5'h00;
            byte_cnt_r            <= 9'h000;
            load_r                <= 1'b0;
            input_pin_bidir_oe_o  <= 1'b0;
            output_pin_bidir_oe_o <= 1'b0;
         end else if (sck_rise) begin
            // input bits are taken on the rising edge only
            case (state_r)
               S_IDLE: begin
                  op_r      <= op_nxt;
                  bit_cnt_r <= bit_cnt_r + 5'h01;
                  if (bit_cnt_r == `LAST_BYTE) begin
                     bit_cnt_r <= 5'h00;
                     kind_r    <= info[`INFO_K_MSB:0];
                     gated_r   <= info[`INFO_GATED];
                     dum_r     <= info[`INFO_DUM_MSB:`INFO_DUM_LSB];
                     if (!info[`INFO_KNOWN]) begin
                        state_r <= S_IGNORE;
                     end else if (info[`INFO_GATED] && !wel_r) begin
                        state_r <= S_IGNORE;
                     end else if (info[`INFO_ADDR]) begin
                        state_r <= S_ADDR;
                     end else begin
                        state_r <= S_DONE;
                     end
                  end
               end
               S_ADDR: begin
                  // only the low 21 bits survive the shift
                  addr_r    <= addr_nxt;
                  bit_cnt_r <= bit_cnt_r + 5'h01;
                  if (bit_cnt_r == `LAST_ADDR) begin
                     if (dum_r != `DUM_0) begin
                        state_r   <= S_DUMMY;
                        bit_cnt_r <= 5'h00;
                     end else begin
                        enter_data(addr_nxt);
                     end
                  end
               end
               S_DUMMY: begin
                  bit_cnt_r <= bit_cnt_r + 5'h01;
                  if (bit_cnt_r == `LAST_BYTE) begin
                     bit_cnt_r <= 5'h00;
                     dum_r     <= dum_r - 2'h1;
                     if (dum_r == `DUM_1) begin
                        enter_data(addr_r);
                     end
                  end
               end
               S_PDATA: begin
                  din_r     <= din_nxt;
                  bit_cnt_r <= bit_cnt_r + 5'h01;
                  if (bit_cnt_r == last_wr) begin
                     bit_cnt_r <= 5'h00;
                     // bytes past the page limit are dropped
                     if (!byte_cnt_r[`PROG_FULL]) begin
                        prog_valid_o <= 1'b1;
                        prog_data_o  <= din_nxt;
                        prog_addr_o  <= addr_r;
                        addr_r       <= addr_r + 21'h000001;
                        byte_cnt_r   <= byte_cnt_r + 9'h001;
                     end
                  end
               end
               default: begin
                  bit_cnt_r <= bit_cnt_r;
               end
            endcase
         end else if (sck_fall && state_r == S_RDATA && !load_r) begin
            // output bits change on the falling edge, msb first
            output_pin_bidir_oe_o <= 1'b1;
            output_pin_bidir_o    <= dout_r[7];
            if (dual_rd) begin
               input_pin_bidir_oe_o <= 1'b1;
               input_pin_bidir_o    <= dout_r[6];
               dout_r               <= {dout_r[5:0], 2'b00};
            end else begin
               dout_r <= {dout_r[6:0], 1'b0};
            end
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == last_rd) begin
               bit_cnt_r <= 5'h00;
               start_fetch(addr_r);
            end
         end
      end
   end
endmodule // serial_flash_command_frontend

//--- flash_frontend_sva.sv
// assertions on the serial flash front end pulses and pin drivers
// bound to the front end; sees only its ports
`timescale 1ns/1ps
`include "flash_frontend_defs.vh"
module flash_frontend_sva (
   input wire              sys_clk_i,
   input wire              rst_i,
   input wire              cs_n_i,
   input wire              sck_i,
   input wire              input_pin_bidir_o,
   input wire              input_pin_bidir_oe_o,
   input wire              output_pin_bidir_o,
   input wire              output_pin_bidir_oe_o,
   input wire              rd_strobe_o,
   input wire              prog_valid_o,
   input wire              op_valid_o,
   input wire              write_enable_latch_o,
   input wire [`SECT_N-1:0] sector_prot_o
);
   reg [3:0] hi_cnt_r;
   // cycles that chip select has stayed high, saturating
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i)
         hi_cnt_r <= 4'h0;
      else if (!cs_n_i)
         hi_cnt_r <= 4'h0;
      else if (hi_cnt_r != 4'hf)
         hi_cnt_r <= hi_cnt_r + 4'h1;
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_oe_released: assert property (hi_cnt_r > 4'h7 |-> !output_pin_bidir_oe_o && !input_pin_bidir_oe_o)
      else $error("data pin driven while deselected");
   a_idle_quiet: assert property (hi_cnt_r > 4'h7 |-> !rd_strobe_o && !prog_valid_o)
      else $error("transfer pulse while deselected");
   a_op_commit: assert property (op_valid_o |-> cs_n_i ##1 !op_valid_o)
      else $error("command commit outside deselect");
   a_prog_gated: assert property (prog_valid_o |-> write_enable_latch_o)
      else $error("program byte without write enable");
   a_wel_set: assert property ($rose(write_enable_latch_o) |-> cs_n_i && $past(cs_n_i, 2))
      else $error("write enable set inside a frame");
   a_prot_commit: assert property (!$stable(sector_prot_o) |-> cs_n_i && $past(cs_n_i, 2))
      else $error("sector flag changed inside a frame");
   a_so_on_fall: assert property (output_pin_bidir_oe_o && $past(output_pin_bidir_oe_o)
      && !$stable(output_pin_bidir_o) |-> !$past(sck_i))
      else $error("output data changed outside low clock");
   a_si_on_fall: assert property (input_pin_bidir_oe_o && $past(input_pin_bidir_oe_o)
      && !$stable(input_pin_bidir_o) |-> !$past(sck_i))
      else $error("second data pin changed outside low clock");
   a_dual_both: assert property (input_pin_bidir_oe_o |-> output_pin_bidir_oe_o)
      else $error("second pin driven without output pin");
   a_strobe_gap: assert property (rd_strobe_o |=> !rd_strobe_o [*3])
      else $error("read strobes too close");
   c_commit: cover property (op_valid_o);
   c_dual: cover property (input_pin_bidir_oe_o);
   c_prog: cover property (prog_valid_o);
   c_prot: cover property (sector_prot_o != 32'h0);
endmodule // flash_frontend_sva

bind serial_flash_command_frontend flash_frontend_sva u_sva (
   .sys_clk_i(sys_clk_i),
   .rst_i(rst_i),
   .cs_n_i(cs_n_i),
   .sck_i(sck_i),
   .input_pin_bidir_o(input_pin_bidir_o),
   .input_pin_bidir_oe_o(input_pin_bidir_oe_o),
   .output_pin_bidir_o(output_pin_bidir_o),
   .output_pin_bidir_oe_o(output_pin_bidir_oe_o),
   .rd_strobe_o(rd_strobe_o),
   .prog_valid_o(prog_valid_o),
   .op_valid_o(op_valid_o),
   .write_enable_latch_o(write_enable_latch_o),
   .sector_prot_o(sector_prot_o)
);

//--- spi_host.sv
// host serial master model: frames and shifts single and dual bytes
// paced by sys_clk; sck half period is four sys_clk cycles
`timescale 1ns/1ps
module spi_host (
   input  wire sys_clk_i,
   input  wire si_i,
   input  wire so_i,
   output reg  cs_n_o,
   output reg  sck_o,
   output reg  si_o,
   output reg  si_en_o,
   output reg  so_o,
   output reg  so_en_o
);
   reg idle_r;
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
      si_en_o = 1'b0;
      so_o = 1'b0;
      so_en_o = 1'b0;
      idle_r = 1'b0;
   end
   task wt(input integer n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   // park sck at the mode idle level, then select
   task start(input mode3);
      begin
         wt(1);
         idle_r = mode3;
         sck_o <= mode3;
         wt(4);
         cs_n_o <= 1'b0;
         wt(4);
      end
   endtask
   // md: 0 single, 1 dual write, 2 dual read (both lines released)
   task bitx(input h, input l, input [1:0] md, output rh, output rl);
      begin
         sck_o <= 1'b0;
         si_o <= (md == 2'd1) ? l : h;
         si_en_o <= (md != 2'd2);
         so_o <= h;
         so_en_o <= (md == 2'd1);
         wt(4);
         sck_o <= 1'b1;
         wt(1);
         rh = so_i;
         rl = si_i;
         wt(3);
      end
   endtask
   task xfer(input [7:0] b, input [1:0] md, output [7:0] r);
      integer i;
      reg rh, rl;
      begin
         r = 8'h00;
         if (md == 2'd0) begin
            for (i = 7; i >= 0; i = i - 1) begin
               bitx(b[i], 1'b0, md, rh, rl);
               r = {r[6:0], rh};
            end
         end else begin
            for (i = 7; i > 0; i = i - 2) begin
               bitx(b[i], b[i-1], md, rh, rl);
               r = {r[5:0], rh, rl};
            end
         end
      end
   endtask
   task stop;
      begin
         wt(4);
         sck_o <= idle_r;
         si_en_o <= 1'b0;
         so_en_o <= 1'b0;
         wt(4);
         cs_n_o <= 1'b1;
         wt(8);
      end
   endtask
endmodule // spi_host

//--- serial_flash_command_frontend_tb.sv
// testbench: host model sends command frames, a monitor checks pulses
// assumes the front end, its header and the host model are compiled first
`timescale 1ns/1ps
`include "flash_frontend_defs.vh"
module serial_flash_command_frontend_tb;
   reg         sys_clk_i;
   reg         rst_i;
   reg         fuzz;
   reg         m3;
   integer     seed;
   integer     n_fail;
   integer     checked;
   reg  [31:0] prot_m;
   reg  [23:0] a0;
   reg  [7:0]  rb;
   reg  [25:0] eo;
   reg  [28:0] ep;
   reg  [25:0] qo[$];
   reg  [28:0] qp[$];
   wire        cs_n, sck, h_si, h_si_en, h_so, h_so_en;
   wire        si_o, si_oe, so_o, so_oe, si_line, so_line;
   wire        rd_strobe, prog_valid, op_valid, write_enable_latch;
   wire [20:0] rd_addr, prog_addr, op_addr;
   wire [7:0]  rd_data, prog_data;
   wire [3:0]  op_kind;
   wire [31:0] prot;
   function [7:0] mem(input [20:0] x);
      mem = x[7:0] ^ {3'h5, x[20:16]};
   endfunction
   function [23:0] rnd(input integer w);
      integer t;
      begin
         t = $random(seed);
         rnd = t[23:0];
      end
   endfunction
   // released lines toggle so a stale level never passes for data
   assign si_line = si_oe ? si_o : (h_si_en ? h_si : fuzz);
   assign so_line = so_oe ? so_o : (h_so_en ? h_so : fuzz);
   assign rd_data = mem(rd_addr);
   always #20 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) fuzz <= ~fuzz;
   spi_host h (.sys_clk_i(sys_clk_i), .si_i(si_line), .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck),
      .si_o(h_si), .si_en_o(h_si_en), .so_o(h_so), .so_en_o(h_so_en));
   serial_flash_command_frontend uut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck),
      .input_pin_bidir_i(si_line), .input_pin_bidir_o(si_o), .input_pin_bidir_oe_o(si_oe),
      .output_pin_bidir_i(so_line), .output_pin_bidir_o(so_o), .output_pin_bidir_oe_o(so_oe),
      .rd_strobe_o(rd_strobe), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
      .prog_valid_o(prog_valid), .prog_addr_o(prog_addr), .prog_data_o(prog_data),
      .op_valid_o(op_valid), .op_kind_o(op_kind), .op_addr_o(op_addr),
      .write_enable_latch_o(write_enable_latch), .sector_prot_o(prot));
   task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
      begin
         checked = checked + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("mismatch %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   // md: 0 single read, 1 dual write, 2 dual read, 3 single write
   task txn(input [7:0] op, input ad, input [23:0] a, input integer dm, input integer n, input [1:0] md);
      integer i;
      reg [23:0] t;
      reg [7:0] r, e;
      reg [20:0] x;
      begin
         m3 = ~m3;
         h.start(m3);
         h.xfer(op, 2'd0, r);
         if (ad)
            for (i = 16; i >= 0; i = i - 8)
               h.xfer(a[i +: 8], 2'd0, r);
         for (i = 0; i < dm; i = i + 1) begin
            t = rnd(0);
            h.xfer(t[7:0], 2'd0, r);
         end
         for (i = 0; i < n; i = i + 1) begin
            x = a[20:0] + i;
            t = rnd(0);
            if (md[0]) begin
               qp.push_back({x, t[7:0]});
               h.xfer(t[7:0], (md == 2'd3) ? 2'd0 : md, r);
            end else begin
               h.xfer(8'h00, md, r);
               e = (op == `OPC_RDPROT) ? {8{prot_m[a[20:16]]}} : mem(x);
               chk("rd_byte", e, r);
            end
         end
         h.stop;
      end
   endtask
   task cmd(input [7:0] op, input [3:0] k, input ad, input we, input integer n, input [1:0] md);
      reg [23:0] a;
      begin
         a = rnd(0);
         if (we)
            txn(`OPC_WREN, 1'b0, 24'h0, 0, 0, 2'd0);
         qo.push_back({ad, k, a[20:0]});
         txn(op, ad, a, 0, n, md);
      end
   endtask
   task pset(input [7:0] op, input v, input [23:0] a);
      begin
         txn(`OPC_WREN, 1'b0, 24'h0, 0, 0, 2'd0);
         txn(op, 1'b1, a, 0, 0, 2'd0);
         prot_m[a[20:16]] = v;
         chk("prot", prot_m, prot);
         txn(`OPC_RDPROT, 1'b1, a, 0, 2, 2'd0);
      end
   endtask
   // op_valid and prog_valid pulses, suspend and resume included, are matched in order
   always @(posedge sys_clk_i) begin
      if (op_valid === 1'b1) begin
         if (qo.size() == 0)
            chk("op_spare", 32'h0, 32'h1);
         else begin
            eo = qo.pop_front();
            chk("op_kind", eo[24:21], op_kind);
            if (eo[25])
               chk("op_addr", eo[20:0], op_addr);
         end
      end
      if (prog_valid === 1'b1) begin
         if (qp.size() == 0)
            chk("pg_spare", 32'h0, 32'h1);
         else begin
            ep = qp.pop_front();
            chk("pg_addr", ep[28:8], prog_addr);
            chk("pg_data", ep[7:0], prog_data);
         end
      end
   end
   initial begin
      repeat (60000) @(posedge sys_clk_i);
      n_fail = n_fail + 1;
      final_report;
   end
   initial begin
      sys_clk_i = 1'b0;
      rst_i = 1'b1;
      fuzz = 1'b0;
      m3 = 1'b0;
      seed = 37674;
      n_fail = 0;
      checked = 0;
      prot_m = 32'h0;
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      chk("wel", 32'h0, write_enable_latch);
      chk("prot", 32'h0, prot);
      txn(8'hff, 1'b1, 24'h060606, 0, 0, 2'd0);
      chk("wel", 32'h0, write_enable_latch);
      txn(`OPC_ERASE4, 1'b1, 24'h0, 0, 0, 2'd0);
      txn(`OPC_WREN, 1'b0, 24'h0, 0, 0, 2'd0);
      chk("wel", 32'h1, write_enable_latch);
      h.start(1'b0);
      h.xfer(`OPC_ERASE64, 2'd0, rb);
      h.xfer(8'h12, 2'd0, rb);
      h.stop;
      chk("wel", 32'h1, write_enable_latch);
      txn(`OPC_WRDI, 1'b0, 24'h0, 0, 0, 2'd0);
      chk("wel", 32'h0, write_enable_latch);
      cmd(`OPC_ERASE4, `K_ERASE4, 1'b1, 1'b1, 0, 2'd0);
      cmd(`OPC_ERASE32, `K_ERASE32, 1'b1, 1'b1, 0, 2'd0);
      cmd(`OPC_ERASE64, `K_ERASE64, 1'b1, 1'b1, 0, 2'd0);
      cmd(`OPC_CHIP, `K_CHIP, 1'b0, 1'b1, 0, 2'd0);
      chk("wel", 32'h0, write_enable_latch);
      cmd(`OPC_SUSPEND, `K_SUSPEND, 1'b0, 1'b0, 0, 2'd0);
      cmd(`OPC_RESUME, `K_RESUME, 1'b0, 1'b0, 0, 2'd0);
      cmd(`OPC_PROG, `K_PROG, 1'b1, 1'b1, 3, 2'd3);
      cmd(`OPC_PROG_DU, `K_DPROG, 1'b1, 1'b1, 4, 2'd1);
      chk("wel", 32'h0, write_enable_latch);
      a0 = rnd(0);
      pset(`OPC_PROT, 1'b1, a0);
      pset(`OPC_UNPROT, 1'b0, a0);
      txn(`OPC_RD_DUM0, 1'b1, 24'hfffffe, 0, 4, 2'd0);
      txn(`OPC_RD_DUM1, 1'b1, rnd(0), 1, 2, 2'd0);
      txn(`OPC_RD_DUM2, 1'b1, rnd(0), 2, 2, 2'd0);
      txn(`OPC_RD_DUAL, 1'b1, 24'h1fffff, 1, 3, 2'd2);
      chk("queue", 32'h0, qo.size() + qp.size());
      final_report;
   end
endmodule // serial_flash_command_frontend_tb
